// ==== core/mfpm_defines.svh ====
`ifndef MFPM_DEFINES_SVH
`define MFPM_DEFINES_SVH

// ==========================================================================
// Register offsets (byte addresses are offset * 4)
`define MFPM_IDX_SEC_ROUTE     7'h1f
`define MFPM_IDX_GPIO_CTL      7'h34
`define MFPM_IDX_DOUT_CTL      7'h35
`define MFPM_IDX_DIN_CTL       7'h36
`define MFPM_IDX_SOUT_CTL      7'h37
`define MFPM_IDX_SCLK_CTL      7'h38
`define MFPM_IDX_HSD_CTL       7'h43
`define MFPM_IDX_IN_STATUS     7'h44

// ==========================================================================
// Field positions
`define MFPM_DOUT_SEL_HI       3
`define MFPM_DOUT_SEL_LO       1
`define MFPM_SOUT_SEL_HI       4
`define MFPM_SOUT_SEL_LO       1
`define MFPM_GPIO_SEL_HI       5
`define MFPM_GPIO_SEL_LO       2
`define MFPM_DIN_SEL_HI        2
`define MFPM_DIN_SEL_LO        1
`define MFPM_SCLK_SEL_HI       2
`define MFPM_SCLK_SEL_LO       1
`define MFPM_HSD_EN_BIT        7
`define MFPM_SEC_DIN_BIT       0

// ==========================================================================
// Reset values and bus answers
`define MFPM_REG_RESET         8'h00
`define MFPM_UNMAPPED_DATA     32'h00000000
`define MFPM_READ_LATENCY      1

`endif

// ==== core/mfpm_pkg.sv ====
package mfpm_pkg;

  typedef logic [7:0] mfpm_reg_t;

  // Output sources on the serial-data-out pin
  typedef enum logic [2:0] {
    MFPM_DOUT_OFF   = 3'h0,
    MFPM_DOUT_PRI   = 3'h1,
    MFPM_DOUT_GPO1  = 3'h2,
    MFPM_DOUT_AUX   = 3'h3,
    MFPM_DOUT_FIRST_INTERRUPT_OUTPUT  = 3'h4,
    MFPM_DOUT_SECOND_INTERRUPT_OUTPUT  = 3'h5,
    MFPM_DOUT_SBCLK = 3'h6,
    MFPM_DOUT_SWCLK = 3'h7
  } mfpm_dout_e;

  // Output sources on the serial-return pin
  typedef enum logic [3:0] {
    MFPM_SOUT_GPO2  = 4'h2,
    MFPM_SOUT_AUX   = 4'h3,
    MFPM_SOUT_FIRST_INTERRUPT_OUTPUT  = 4'h4,
    MFPM_SOUT_WCLK  = 4'h6,
    MFPM_SOUT_SDOUT = 4'h8,
    MFPM_SOUT_SBCLK = 4'h9,
    MFPM_SOUT_SWCLK = 4'ha
  } mfpm_sout_e;

  // Functions on the general pin
  typedef enum logic [3:0] {
    MFPM_GPIO_IN    = 4'h1,
    MFPM_GPIO_GPI3  = 4'h2,
    MFPM_GPIO_GPO3  = 4'h3,
    MFPM_GPIO_AUX   = 4'h4,
    MFPM_GPIO_FIRST_INTERRUPT_OUTPUT  = 4'h5,
    MFPM_GPIO_WCLK  = 4'h7,
    MFPM_GPIO_SBCLK = 4'h8,
    MFPM_GPIO_SWCLK = 4'h9
  } mfpm_gpio_e;

  typedef enum logic [1:0] {
    MFPM_IN_HSD  = 2'h0,
    MFPM_IN_PRI  = 2'h1,
    MFPM_IN_GPI  = 2'h2
  } mfpm_in_e;

  // Bus slave states, Gray along idle -> answer
  typedef enum logic [1:0] {
    MFPM_BUS_IDLE = 2'b00,
    MFPM_BUS_ACK  = 2'b01
  } mfpm_bus_e;

endpackage

// ==== core/mfpm_sync.sv ====
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser for pin inputs
module mfpm_sync #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_rst,
  // Data
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule

`default_nettype wire

// ==== core/mfpm_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "mfpm_defines.svh"

// Avalon-MM register file; answers every access one cycle after it is seen
module mfpm_regs (
  // Clock and reset
  input  wire logic              i_clock,
  input  wire logic              i_rst,
  // Avalon-MM slave
  input  wire logic [8:0]        i_avs_address,
  input  wire logic              i_avs_read,
  input  wire logic              i_avs_write,
  input  wire logic [31:0]       i_avs_writedata,
  input  wire logic [3:0]        i_avs_byteenable,
  output logic      [31:0]       o_avs_readdata,
  output logic                   o_avs_waitrequest,
  // Register contents
  output mfpm_pkg::mfpm_reg_t    o_sec_route,
  output mfpm_pkg::mfpm_reg_t    o_gpio_ctl,
  output mfpm_pkg::mfpm_reg_t    o_dout_ctl,
  output mfpm_pkg::mfpm_reg_t    o_din_ctl,
  output mfpm_pkg::mfpm_reg_t    o_sout_ctl,
  output mfpm_pkg::mfpm_reg_t    o_sclk_ctl,
  output mfpm_pkg::mfpm_reg_t    o_hsd_ctl,
  // Live pin status
  input  wire mfpm_pkg::mfpm_reg_t i_status
);

  // ========================================================================
  // Decode
  mfpm_pkg::mfpm_bus_e state_q;
  mfpm_pkg::mfpm_bus_e state_d;
  mfpm_pkg::mfpm_reg_t regs_q [7];
  logic [31:0]         rdata_q;
  logic [31:0]         rdata_d;
  logic [6:0]          index;
  logic                req;
  logic                take;
  logic                wr_lane0;
  logic [2:0]          slot;
  logic                hit;
  logic [3:0]          code;
  logic                waitreq_q;

  function automatic logic [3:0] decode(input logic [6:0] idx);
    case (idx)
      `MFPM_IDX_SEC_ROUTE: decode = 4'h0;
      `MFPM_IDX_GPIO_CTL:  decode = 4'h1;
      `MFPM_IDX_DOUT_CTL:  decode = 4'h2;
      `MFPM_IDX_DIN_CTL:   decode = 4'h3;
      `MFPM_IDX_SOUT_CTL:  decode = 4'h4;
      `MFPM_IDX_SCLK_CTL:  decode = 4'h5;
      `MFPM_IDX_HSD_CTL:   decode = 4'h6;
      `MFPM_IDX_IN_STATUS: decode = 4'h7;
      default:             decode = 4'h8;
    endcase
  endfunction

  assign index    = i_avs_address[8:2];
  assign req      = i_avs_read | i_avs_write;
  assign take     = req && (state_q == mfpm_pkg::MFPM_BUS_ACK);
  assign code     = decode(index);
  assign slot     = code[2:0];
  assign hit      = ~code[3] && (slot != 3'h7);
  assign wr_lane0 = take && i_avs_write && i_avs_byteenable[0] && hit;
  assign state_d  = (req && state_q == mfpm_pkg::MFPM_BUS_IDLE) ? mfpm_pkg::MFPM_BUS_ACK
                                                               : mfpm_pkg::MFPM_BUS_IDLE;

  always_comb begin
    rdata_d = `MFPM_UNMAPPED_DATA;
    if (hit) begin
      rdata_d = {24'h000000, regs_q[slot]};
    end else if (code == 4'h7) begin
      rdata_d = {24'h000000, i_status};
    end
  end

  // ========================================================================
  // Storage
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_q <= mfpm_pkg::MFPM_BUS_IDLE;
      waitreq_q <= 1'b1;
      rdata_q <= `MFPM_UNMAPPED_DATA;
      for (int k = 0; k < 7; k++) begin
        regs_q[k] <= `MFPM_REG_RESET;
      end
    end else begin
      state_q <= state_d;
      waitreq_q <= (state_d != mfpm_pkg::MFPM_BUS_ACK);
      rdata_q <= rdata_d;
      if (wr_lane0) begin
        regs_q[slot] <= i_avs_writedata[7:0];
      end
    end
  end

  // Waitrequest comes from a flop, low only in the answer cycle
  assign o_avs_waitrequest = waitreq_q;
  assign o_avs_readdata    = rdata_q;
  assign o_sec_route       = regs_q[0];
  assign o_gpio_ctl        = regs_q[1];
  assign o_dout_ctl        = regs_q[2];
  assign o_din_ctl         = regs_q[3];
  assign o_sout_ctl        = regs_q[4];
  assign o_sclk_ctl        = regs_q[5];
  assign o_hsd_ctl         = regs_q[6];

endmodule

`default_nettype wire

// ==== core/mfpm_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "mfpm_defines.svh"

// Contract
// - Serial-out pin source chosen by its register bits 3:1.
// - Serial-return pin source chosen by its register bits 4:1.
// - General pin function chosen by its register bits 5:2.
// - Serial-in pin: 01 primary data input, 10 general input one.
// - Serial-clock pin is general input two when its bits 2:1 are 10.
// - Headset detect from serial-clock pin when select 00 and enable bit 7 set.
// - Secondary data input from general pin when route bit 0 is 0, select 0001.
// - Serial-out pin carries second interrupt when its bits 3:1 are 101.
module mfpm_top (
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  // Avalon-MM slave
  input  wire logic [8:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  // Internal function sources
  input  wire logic        i_pri_data_out,
  input  wire logic        i_gpo1,
  input  wire logic        i_gpo2,
  input  wire logic        i_gpo3,
  input  wire logic        i_aux_clock,
  input  wire logic        i_first_interrupt,
  input  wire logic        i_second_interrupt,
  input  wire logic        i_conv_word_clock,
  input  wire logic        i_sec_data_out,
  input  wire logic        i_sec_bit_clock,
  input  wire logic        i_sec_word_clock,
  input  wire logic        i_sec_din_alt,
  // Multifunction pins
  input  wire logic        i_serial_in_multi_pin,
  input  wire logic        i_serial_clock_multi_pin,
  input  wire logic        i_general_multi_pin,
  output logic             o_serial_out_multi_pin,
  output logic             o_serial_out_multi_pin_oe,
  output logic             o_serial_return_multi_pin,
  output logic             o_serial_return_multi_pin_oe,
  output logic             o_general_multi_pin,
  output logic             o_general_multi_pin_oe,
  // Received functions
  output logic             o_pri_data_in,
  output logic             o_gpi1,
  output logic             o_gpi2,
  output logic             o_gpi3,
  output logic             o_headset_detect,
  output logic             o_sec_data_in
);

  // ==========================================================================
  // Registers
  mfpm_pkg::mfpm_reg_t sec_route;
  mfpm_pkg::mfpm_reg_t gpio_ctl;
  mfpm_pkg::mfpm_reg_t dout_ctl;
  mfpm_pkg::mfpm_reg_t din_ctl;
  mfpm_pkg::mfpm_reg_t sout_ctl;
  mfpm_pkg::mfpm_reg_t sclk_ctl;
  mfpm_pkg::mfpm_reg_t hsd_ctl;
  mfpm_pkg::mfpm_reg_t status;
  logic [31:0]         rdata;
  logic                waitreq;
  logic [2:0]          pins_sync;

  mfpm_regs u_regs (
    .i_clock          (i_clock),
    .i_rst            (i_rst),
    .i_avs_address    (i_avs_address),
    .i_avs_read       (i_avs_read),
    .i_avs_write      (i_avs_write),
    .i_avs_writedata  (i_avs_writedata),
    .i_avs_byteenable (i_avs_byteenable),
    .o_avs_readdata   (rdata),
    .o_avs_waitrequest(waitreq),
    .o_sec_route      (sec_route),
    .o_gpio_ctl       (gpio_ctl),
    .o_dout_ctl       (dout_ctl),
    .o_din_ctl        (din_ctl),
    .o_sout_ctl       (sout_ctl),
    .o_sclk_ctl       (sclk_ctl),
    .o_hsd_ctl        (hsd_ctl),
    .i_status         (status)
  );

  // Bus answer passes straight through; regs module answers from flops
  assign o_avs_readdata    = rdata;
  assign o_avs_waitrequest = waitreq;

  // ==========================================================================
  // Pin input synchronisers
  mfpm_sync #(.WIDTH(3)) u_sync (
    .i_clock(i_clock),
    .i_rst  (i_rst),
    .i_async({i_general_multi_pin, i_serial_clock_multi_pin, i_serial_in_multi_pin}),
    .o_sync (pins_sync)
  );

  // ==========================================================================
  // Select fields
  logic [2:0] dout_sel;
  logic [3:0] sout_sel;
  logic [3:0] gpio_sel;
  logic [1:0] din_sel;
  logic [1:0] sclk_sel;

  assign dout_sel = dout_ctl[`MFPM_DOUT_SEL_HI:`MFPM_DOUT_SEL_LO];
  assign sout_sel = sout_ctl[`MFPM_SOUT_SEL_HI:`MFPM_SOUT_SEL_LO];
  assign gpio_sel = gpio_ctl[`MFPM_GPIO_SEL_HI:`MFPM_GPIO_SEL_LO];
  assign din_sel  = din_ctl[`MFPM_DIN_SEL_HI:`MFPM_DIN_SEL_LO];
  assign sclk_sel = sclk_ctl[`MFPM_SCLK_SEL_HI:`MFPM_SCLK_SEL_LO];

  // ==========================================================================
  // Output muxes; each returns {enable, level}
  logic [1:0] dout_d;
  logic [1:0] sout_d;
  logic [1:0] gpio_d;

  always_comb begin
    case (mfpm_pkg::mfpm_dout_e'(dout_sel))
      mfpm_pkg::MFPM_DOUT_PRI:   dout_d = {1'b1, i_pri_data_out};
      mfpm_pkg::MFPM_DOUT_GPO1:  dout_d = {1'b1, i_gpo1};
      mfpm_pkg::MFPM_DOUT_AUX:   dout_d = {1'b1, i_aux_clock};
      mfpm_pkg::MFPM_DOUT_FIRST_INTERRUPT_OUTPUT:  dout_d = {1'b1, i_first_interrupt};
      mfpm_pkg::MFPM_DOUT_SECOND_INTERRUPT_OUTPUT:  dout_d = {1'b1, i_second_interrupt};
      mfpm_pkg::MFPM_DOUT_SBCLK: dout_d = {1'b1, i_sec_bit_clock};
      mfpm_pkg::MFPM_DOUT_SWCLK: dout_d = {1'b1, i_sec_word_clock};
      default:                   dout_d = 2'h0;
    endcase
  end

  always_comb begin
    case (mfpm_pkg::mfpm_sout_e'(sout_sel))
      mfpm_pkg::MFPM_SOUT_GPO2:  sout_d = {1'b1, i_gpo2};
      mfpm_pkg::MFPM_SOUT_AUX:   sout_d = {1'b1, i_aux_clock};
      mfpm_pkg::MFPM_SOUT_FIRST_INTERRUPT_OUTPUT:  sout_d = {1'b1, i_first_interrupt};
      mfpm_pkg::MFPM_SOUT_WCLK:  sout_d = {1'b1, i_conv_word_clock};
      mfpm_pkg::MFPM_SOUT_SDOUT: sout_d = {1'b1, i_sec_data_out};
      mfpm_pkg::MFPM_SOUT_SBCLK: sout_d = {1'b1, i_sec_bit_clock};
      mfpm_pkg::MFPM_SOUT_SWCLK: sout_d = {1'b1, i_sec_word_clock};
      default:                   sout_d = 2'h0;
    endcase
  end

  // Input codes 0001 and 0010 leave the driver off so the pin can be read
  always_comb begin
    case (mfpm_pkg::mfpm_gpio_e'(gpio_sel))
      mfpm_pkg::MFPM_GPIO_GPO3:  gpio_d = {1'b1, i_gpo3};
      mfpm_pkg::MFPM_GPIO_AUX:   gpio_d = {1'b1, i_aux_clock};
      mfpm_pkg::MFPM_GPIO_FIRST_INTERRUPT_OUTPUT:  gpio_d = {1'b1, i_first_interrupt};
      mfpm_pkg::MFPM_GPIO_WCLK:  gpio_d = {1'b1, i_conv_word_clock};
      mfpm_pkg::MFPM_GPIO_SBCLK: gpio_d = {1'b1, i_sec_bit_clock};
      mfpm_pkg::MFPM_GPIO_SWCLK: gpio_d = {1'b1, i_sec_word_clock};
      default:                   gpio_d = 2'h0;
    endcase
  end

  // ==========================================================================
  // Input routing
  logic din_pri;
  logic din_gpi;
  logic sclk_gpi;
  logic sclk_hsd;
  logic gpio_gpi;
  logic gpio_sec;
  logic sec_din_d;

  assign din_pri   = (din_sel == 2'(mfpm_pkg::MFPM_IN_PRI)) & pins_sync[0];
  assign din_gpi   = (din_sel == 2'(mfpm_pkg::MFPM_IN_GPI)) & pins_sync[0];
  assign sclk_gpi  = (sclk_sel == 2'(mfpm_pkg::MFPM_IN_GPI)) & pins_sync[1];
  assign sclk_hsd  = (sclk_sel == 2'(mfpm_pkg::MFPM_IN_HSD))
                   & hsd_ctl[`MFPM_HSD_EN_BIT] & pins_sync[1];
  assign gpio_gpi  = (gpio_sel == 4'(mfpm_pkg::MFPM_GPIO_GPI3)) & pins_sync[2];
  assign gpio_sec  = (gpio_sel == 4'(mfpm_pkg::MFPM_GPIO_IN)) & pins_sync[2];
  // Route bit 0 set selects the alternate source for secondary data
  assign sec_din_d = sec_route[`MFPM_SEC_DIN_BIT] ? i_sec_din_alt : gpio_sec;

  assign status = {5'h00, pins_sync};

  // ==========================================================================
  // Output flops
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      {o_serial_out_multi_pin_oe, o_serial_out_multi_pin}       <= 2'h0;
      {o_serial_return_multi_pin_oe, o_serial_return_multi_pin} <= 2'h0;
      {o_general_multi_pin_oe, o_general_multi_pin}             <= 2'h0;
      {o_pri_data_in, o_gpi1, o_gpi2, o_gpi3}                   <= 4'h0;
      o_headset_detect                                          <= 1'b0;
      o_sec_data_in                                             <= 1'b0;
    end else begin
      {o_serial_out_multi_pin_oe, o_serial_out_multi_pin}       <= dout_d;
      {o_serial_return_multi_pin_oe, o_serial_return_multi_pin} <= sout_d;
      {o_general_multi_pin_oe, o_general_multi_pin}             <= gpio_d;
      {o_pri_data_in, o_gpi1, o_gpi2, o_gpi3} <= {din_pri, din_gpi, sclk_gpi, gpio_gpi};
      o_headset_detect                                          <= sclk_hsd;
      o_sec_data_in                                             <= sec_din_d;
    end
  end

  // ==========================================================================
  // Checks
  AST_DOUT_PRI: assert property (@(posedge i_clock) disable iff (i_rst)
    dout_sel == 3'h1 |=> o_serial_out_multi_pin_oe && o_serial_out_multi_pin == $past(i_pri_data_out))
    else $error("serial-out pin not carrying primary data");

  AST_DOUT_SECOND_INTERRUPT_OUTPUT: assert property (@(posedge i_clock) disable iff (i_rst)
    dout_sel == 3'h5 |=> o_serial_out_multi_pin == $past(i_second_interrupt))
    else $error("serial-out pin not carrying second interrupt");

  AST_DOUT_OFF: assert property (@(posedge i_clock) disable iff (i_rst)
    dout_sel == 3'h0 |=> !o_serial_out_multi_pin_oe)
    else $error("serial-out driver on for unlisted code");

  AST_SOUT_SDOUT: assert property (@(posedge i_clock) disable iff (i_rst)
    sout_sel == 4'h8 |=> o_serial_return_multi_pin_oe && o_serial_return_multi_pin == $past(i_sec_data_out))
    else $error("serial-return pin not carrying secondary data");

  AST_GPIO_SWCLK: assert property (@(posedge i_clock) disable iff (i_rst)
    gpio_sel == 4'h9 |=> o_general_multi_pin == $past(i_sec_word_clock))
    else $error("general pin not carrying secondary word clock");

  AST_GPIO_GPI3: assert property (@(posedge i_clock) disable iff (i_rst)
    gpio_sel == 4'h2 |=> o_gpi3 == $past(pins_sync[2]) && !o_general_multi_pin_oe)
    else $error("general pin not general input three");

  AST_GPIO_OFF: assert property (@(posedge i_clock) disable iff (i_rst)
    gpio_sel inside {4'h0, 4'h1, 4'h2, 4'h6, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf} |=> !o_general_multi_pin_oe)
    else $error("general driver on for an input or unlisted code");

  AST_DIN_PRI: assert property (@(posedge i_clock) disable iff (i_rst)
    din_sel == 2'h1 |=> o_pri_data_in == $past(pins_sync[0]) && !o_gpi1)
    else $error("serial-in pin not primary data input");

  AST_DIN_GPI: assert property (@(posedge i_clock) disable iff (i_rst)
    din_sel == 2'h2 |=> !o_pri_data_in && o_gpi1 == $past(pins_sync[0]))
    else $error("serial-in pin mis-routed");

  AST_SCLK_GPI: assert property (@(posedge i_clock) disable iff (i_rst)
    sclk_sel == 2'h2 |=> o_gpi2 == $past(pins_sync[1]) && !o_headset_detect)
    else $error("serial-clock pin not general input two");

  AST_HSD: assert property (@(posedge i_clock) disable iff (i_rst)
    !(sclk_sel == 2'h0 && hsd_ctl[`MFPM_HSD_EN_BIT]) |=> !o_headset_detect)
    else $error("headset detect without enable");

  AST_HSD_ON: assert property (@(posedge i_clock) disable iff (i_rst)
    sclk_sel == 2'h0 && hsd_ctl[`MFPM_HSD_EN_BIT] |=> o_headset_detect == $past(pins_sync[1]))
    else $error("headset detect not following serial-clock pin");

  AST_SEC_DIN: assert property (@(posedge i_clock) disable iff (i_rst)
    !sec_route[0] && gpio_sel == 4'h1 |=> o_sec_data_in == $past(pins_sync[2]))
    else $error("secondary data not from general pin");

  AST_SEC_ALT: assert property (@(posedge i_clock) disable iff (i_rst)
    sec_route[`MFPM_SEC_DIN_BIT] |=> o_sec_data_in == $past(i_sec_din_alt))
    else $error("secondary data not from alternate source");

  AST_UNLISTED_OFF: assert property (@(posedge i_clock) disable iff (i_rst)
    sout_sel inside {4'h0, 4'h1, 4'h5, 4'h7, 4'hb, 4'hc, 4'hd, 4'he, 4'hf} |=> !o_serial_return_multi_pin_oe)
    else $error("serial-return driver on for unlisted code");

  COV_DOUT_FIRST_INTERRUPT_OUTPUT: cover property (@(posedge i_clock) disable iff (i_rst) dout_sel == 3'h4);
  COV_HSD:       cover property (@(posedge i_clock) disable iff (i_rst) sclk_hsd);
  COV_SEC_DIN:   cover property (@(posedge i_clock) disable iff (i_rst) gpio_sec && !sec_route[0]);
  COV_GPI3:      cover property (@(posedge i_clock) disable iff (i_rst) gpio_gpi);
  COV_SEC_ALT:   cover property (@(posedge i_clock) disable iff (i_rst) sec_route[0] && i_sec_din_alt);

endmodule

`default_nettype wire

// ==== test/mfpm_pin_partner.sv ====
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Far-side peripherals on the multifunction pins
module mfpm_pin_partner (
  // Levels the peripherals want on the pins
  input  wire logic [2:0] i_drive,
  // Design side of the general pin
  input  wire logic       i_general_out,
  input  wire logic       i_general_oe,
  // Pin levels seen by the design
  output logic            o_serial_in,
  output logic            o_serial_clock,
  output logic            o_general
);
  // Peripheral lets go of the general pin while the design drives it
  assign o_serial_in    = i_drive[0];
  assign o_serial_clock = i_drive[1];
  assign o_general      = i_general_oe ? i_general_out : i_drive[2];
endmodule

`default_nettype wire

// ==== test/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "mfpm_defines.svh"

module testbench;
  localparam logic [6:0] IDX [7] = '{`MFPM_IDX_SEC_ROUTE, `MFPM_IDX_GPIO_CTL, `MFPM_IDX_DOUT_CTL,
    `MFPM_IDX_DIN_CTL, `MFPM_IDX_SOUT_CTL, `MFPM_IDX_SCLK_CTL, `MFPM_IDX_HSD_CTL};
  logic                i_clock;
  logic                i_rst;
  logic [8:0]          i_avs_address;
  logic                i_avs_read;
  logic                i_avs_write;
  logic [31:0]         i_avs_writedata;
  logic [3:0]          i_avs_byteenable;
  logic [31:0]         o_avs_readdata;
  logic                o_avs_waitrequest;
  logic [11:0]         src;
  logic [2:0]          pdrv;
  wire                 pin_si;
  wire                 pin_sc;
  wire                 pin_gp;
  wire  [11:0]         pins;
  logic                pin_chk;
  logic [23:0]         note;
  logic [31:0]         lfsr;
  logic [3:0]          v;
  mfpm_pkg::mfpm_reg_t sh [7];
  mfpm_pkg::mfpm_reg_t vals [7];
  logic [31:0]         rdq [$];
  logic [23:0]         pinq [$];
  int                  errors;
  int                  n_compared;
  int                  i;
  int                  k;

  mfpm_top u_mfpm_top (
    .i_clock, .i_rst, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
    .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest,
    .i_pri_data_out(src[0]), .i_gpo1(src[1]), .i_gpo2(src[2]), .i_gpo3(src[3]),
    .i_aux_clock(src[4]), .i_first_interrupt(src[5]), .i_second_interrupt(src[6]),
    .i_conv_word_clock(src[7]), .i_sec_data_out(src[8]), .i_sec_bit_clock(src[9]),
    .i_sec_word_clock(src[10]), .i_sec_din_alt(src[11]),
    .i_serial_in_multi_pin(pin_si), .i_serial_clock_multi_pin(pin_sc), .i_general_multi_pin(pin_gp),
    .o_serial_out_multi_pin(pins[11]), .o_serial_out_multi_pin_oe(pins[10]),
    .o_serial_return_multi_pin(pins[9]), .o_serial_return_multi_pin_oe(pins[8]),
    .o_general_multi_pin(pins[7]), .o_general_multi_pin_oe(pins[6]),
    .o_pri_data_in(pins[5]), .o_gpi1(pins[4]), .o_gpi2(pins[3]), .o_gpi3(pins[2]),
    .o_headset_detect(pins[1]), .o_sec_data_in(pins[0])
  );

  mfpm_pin_partner u_mfpm_pin_partner (
    .i_drive(pdrv), .i_general_out(pins[7]), .i_general_oe(pins[6]),
    .o_serial_in(pin_si), .o_serial_clock(pin_sc), .o_general(pin_gp)
  );

  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
  endfunction

  // ==========================================================
  // Expected pin vector and care mask
  function automatic logic [23:0] expect_pins(input logic [11:0] s, input logic [2:0] p);
    logic [11:0] e;
    logic [11:0] m;
    logic [3:0]  gs;
    gs = sh[1][5:2];
    e = 12'h0;
    m = 12'hfff;
    case (sh[2][3:1])
      3'h1: e[11] = s[0];
      3'h2: e[11] = s[1];
      3'h3: e[11] = s[4];
      3'h4: e[11] = s[5];
      3'h5: e[11] = s[6];
      3'h6: e[11] = s[9];
      3'h7: e[11] = s[10];
      default: m[11] = 1'b0;
    endcase
    case (sh[4][4:1])
      4'h2: e[9] = s[2];
      4'h3: e[9] = s[4];
      4'h4: e[9] = s[5];
      4'h6: e[9] = s[7];
      4'h8: e[9] = s[8];
      4'h9: e[9] = s[9];
      4'ha: e[9] = s[10];
      default: m[9] = 1'b0;
    endcase
    case (gs)
      4'h3: e[7] = s[3];
      4'h4: e[7] = s[4];
      4'h5: e[7] = s[5];
      4'h7: e[7] = s[7];
      4'h8: e[7] = s[9];
      4'h9: e[7] = s[10];
      default: m[7] = 1'b0;
    endcase
    e[10] = m[11];
    e[8] = m[9];
    e[6] = m[7];
    e[5] = sh[3][2:1] == 2'h1 && p[0];
    e[4] = sh[3][2:1] == 2'h2 && p[0];
    e[3] = sh[5][2:1] == 2'h2 && p[1];
    e[2] = gs == 4'h2 && p[2];
    e[1] = sh[5][2:1] == 2'h0 && sh[6][7] && p[1];
    e[0] = sh[0][0] ? s[11] : (gs == 4'h1 && p[2]);
    return {m, e & m};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("compared=%0d errors=%0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ==========================================================
  // Avalon-MM master: hold until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [6:0] idx, input logic [7:0] d, input logic [3:0] be);
    @(posedge i_clock);
    lfsr = lfsr_next(lfsr);
    i_avs_address <= {idx, 2'h0};
    i_avs_writedata <= {lfsr[23:0], d};
    i_avs_byteenable <= be;
    i_avs_write <= wr;
    i_avs_read <= ~wr;
    do @(posedge i_clock); while (o_avs_waitrequest !== 1'b0);
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
  endtask

  task automatic rd(input int n);
    rdq.push_back({24'h0, sh[n]});
    bus(1'b0, IDX[n], 8'h0, 4'hf);
  endtask

  task automatic wr(input int n, input mfpm_pkg::mfpm_reg_t d);
    bus(1'b1, IDX[n], d, 4'h1);
    sh[n] = d;
  endtask

  task automatic ptest;
    @(posedge i_clock);
    lfsr = lfsr_next(lfsr);
    src <= lfsr[11:0];
    pdrv <= lfsr[14:12];
    repeat (4) @(posedge i_clock);
    pinq.push_back(expect_pins(lfsr[11:0], lfsr[14:12]));
    pin_chk <= 1'b1;
    @(posedge i_clock);
    pin_chk <= 1'b0;
  endtask

  // ==========================================================
  // Output monitor takes the oldest note per result
  always @(posedge i_clock) begin
    if (i_avs_read && o_avs_waitrequest === 1'b0 && rdq.size() > 0)
      check(o_avs_readdata, rdq.pop_front()); // Register readback
    if (pin_chk && pinq.size() > 0) begin
      note = pinq.pop_front();
      check({20'h0, pins & note[23:12]}, {20'h0, note[11:0]}); // Pin vector
    end
  end

  initial begin
    #200000;
    errors++;
    $display("watchdog expired");
    end_sim;
  end

  initial begin
    errors = 0;
    n_compared = 0;
    lfsr = 32'h27ca;
    i_rst = 1'b1;
    i_avs_address = 9'h0;
    i_avs_read = 1'b0;
    i_avs_write = 1'b0;
    i_avs_writedata = 32'h0;
    i_avs_byteenable = 4'h0;
    src = 12'h0;
    pdrv = 3'h0;
    pin_chk = 1'b0;
    for (k = 0; k < 7; k++) sh[k] = 8'h00;
    repeat (5) @(posedge i_clock);
    i_rst <= 1'b0;
    for (k = 0; k < 7; k++) rd(k);
    repeat (2) ptest;
    $display("reset test done");
    // Status ignores writes and shows the synced pin levels
    bus(1'b1, `MFPM_IDX_IN_STATUS, 8'hff, 4'hf);
    rdq.push_back({29'h0, pdrv});
    bus(1'b0, `MFPM_IDX_IN_STATUS, 8'h0, 4'hf);
    // Unmapped place and a write without lane 0 are both ignored
    bus(1'b1, 7'h20, 8'h5a, 4'hf);
    rdq.push_back(32'h0);
    bus(1'b0, 7'h20, 8'h0, 4'hf);
    bus(1'b1, IDX[2], 8'hff, 4'he);
    rd(2);
    $display("refused access test done");
    for (i = 0; i < 16; i++) begin
      v = i[3:0];
      vals = '{{7'h0, v[2]}, {2'h0, v, 2'h0}, {4'h0, v[2:0], 1'b0}, {5'h0, v[1:0], 1'b0},
               {3'h0, v, 1'b0}, {5'h0, v[1:0], 1'b0}, {v[3], 7'h0}};
      for (k = 0; k < 7; k++) wr(k, vals[k]);
      for (k = 0; k < 7; k++) rd(k);
      repeat (3) ptest;
    end
    $display("select sweep test done");
    // Second reset in mid-run clears every select
    @(posedge i_clock);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clock);
    i_rst <= 1'b0;
    for (k = 0; k < 7; k++) sh[k] = 8'h00;
    for (k = 0; k < 7; k++) rd(k);
    repeat (2) ptest;
    $display("second reset test done");
    end_sim;
  end
endmodule

`default_nettype wire
